/* hw/corkscrew_defs.vh */
`ifndef CORKSCREW_DEFS_VH
`define CORKSCREW_DEFS_VH

// Time base.
`define CLK_PERIOD_NS   5
`define NS_PER_US       1000
`define US_PER_MS       1000
`define US_PER_S        1000000

// Durations in their own units.
`define TICK_PERIOD_US  1000
`define RUN_TIMEOUT_S   30
`define DEBOUNCE_MS     10
`define BLANK_MS        5
`define PWM_PERIOD_NS   50000

// Reset and fixed levels.
`define DECAY_SLOW      1'b1
`define DUTY_STEP       14'h0001
`define DUTY_RESET      14'h1388

// Synchroniser slots for the asynchronous level inputs.
`define SY_FAULTA       0
`define SY_FAULTB       1
`define SY_OVERCUR      2
`define SY_BELOW        3
`define SY_ABOVE        4
`define SY_EQUAL        5
`define SY_BATTOK       6
`define SY_CHARGER      7
`define SY_COUNT        8

`endif

/* hw/debounce_filter.v */
`timescale 1ns/1ps
`include "corkscrew_defs.vh"

module debounce_filter
#(
    parameter CNT_W        = 8,
    parameter STABLE_TICKS = 10
)
(
    // Clock and reset.
    input  wire clock,
    input  wire rst,
    // Time base and raw contact.
    input  wire tick,
    input  wire rawIn,
    // Filtered level, resets to the released (high) level.
    output reg  level_q
);

    reg             meta_q;
    reg             sync_q;
    reg [CNT_W-1:0] cnt_q;

    // The output only follows after the input has held its new level for
    // STABLE_TICKS tick pulses, so bounce gives a single transition.
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            meta_q  <= 1'b1;
            sync_q  <= 1'b1;
            cnt_q   <= {CNT_W{1'b0}};
            level_q <= 1'b1;
        end
        else
        begin
            meta_q <= rawIn;
            sync_q <= meta_q;
            if (sync_q == level_q)
                cnt_q <= {CNT_W{1'b0}};
            else if (tick)
            begin
                if (cnt_q == STABLE_TICKS[CNT_W-1:0] - 1'b1)
                begin
                    level_q <= sync_q;
                    cnt_q   <= {CNT_W{1'b0}};
                end
                else
                    cnt_q <= cnt_q + 1'b1;
            end
        end
    end

endmodule

/* hw/pwm_chopper.v */
`timescale 1ns/1ps
`include "corkscrew_defs.vh"

module pwm_chopper
#(
    parameter PWM_W         = 14,
    parameter PERIOD_CYCLES = 10000,
    parameter BLANK_W       = 8,
    parameter BLANK_TICKS   = 5
)
(
    // Clock and reset.
    input  wire clock,
    input  wire rst,
    // Control.
    input  wire tick,
    input  wire run,
    // Comparators, already synchronised.
    input  wire overcurrent,
    input  wire regBelow,
    input  wire regAbove,
    input  wire regEqual,
    // Drive.
    output reg  pwmOut_q
);

    reg [PWM_W-1:0]   periodCnt_q;
    reg [PWM_W-1:0]   duty_q;
    reg [BLANK_W-1:0] blankCnt_q;
    reg               blankDone_q;
    reg               chopped_q;
    wire              periodEnd;
    wire              cutNow;

    function [PWM_W-1:0] stepDuty;
        input [PWM_W-1:0] cur;
        input             up;
        input             down;
        begin
            if (up && cur <= PERIOD_CYCLES[PWM_W-1:0] - `DUTY_STEP)
                stepDuty = cur + `DUTY_STEP;
            else if (up)
                stepDuty = PERIOD_CYCLES[PWM_W-1:0];
            else if (down && cur >= `DUTY_STEP)
                stepDuty = cur - `DUTY_STEP;
            else if (down)
                stepDuty = {PWM_W{1'b0}};
            else
                stepDuty = cur;
        end
    endfunction

    assign periodEnd = (periodCnt_q == PERIOD_CYCLES[PWM_W-1:0] - 1'b1);
    assign cutNow    = overcurrent && blankDone_q;

    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            periodCnt_q <= {PWM_W{1'b0}};
            duty_q      <= `DUTY_RESET;
            blankCnt_q  <= {BLANK_W{1'b0}};
            blankDone_q <= 1'b0;
            chopped_q   <= 1'b0;
            pwmOut_q    <= 1'b0;
        end
        else
        begin
            periodCnt_q <= periodEnd ? {PWM_W{1'b0}} : periodCnt_q + 1'b1;
            // Equal holds the duty; below and above step it once a period.
            if (periodEnd && !regEqual)
                duty_q <= stepDuty(duty_q, regBelow, regAbove);
            // Blanking restarts on every motor start to ride out inrush.
            if (!run)
            begin
                blankCnt_q  <= {BLANK_W{1'b0}};
                blankDone_q <= 1'b0;
            end
            else if (tick && !blankDone_q)
            begin
                if (blankCnt_q == BLANK_TICKS[BLANK_W-1:0] - 1'b1)
                    blankDone_q <= 1'b1;
                blankCnt_q <= blankCnt_q + 1'b1;
            end
            if (periodEnd)
                chopped_q <= 1'b0;
            else if (cutNow)
                chopped_q <= 1'b1;
            pwmOut_q <= run && !chopped_q && !cutNow && !periodEnd
                        && (periodCnt_q < duty_q);
        end
    end

endmodule

/* hw/corkscrew_motor_control.v */
`timescale 1ns/1ps
`include "corkscrew_defs.vh"

module corkscrew_motor_control
#(
    parameter TICK_W         = 18,
    parameter TICK_CYCLES    = (`TICK_PERIOD_US * `NS_PER_US) / `CLK_PERIOD_NS,
    parameter RUN_W          = 15,
    parameter RUN_TICKS      = (`RUN_TIMEOUT_S * `US_PER_S) / `TICK_PERIOD_US,
    parameter DEB_W          = 8,
    parameter DEBOUNCE_TICKS = (`DEBOUNCE_MS * `US_PER_MS) / `TICK_PERIOD_US,
    parameter BLANK_W        = 8,
    parameter BLANK_TICKS    = (`BLANK_MS * `US_PER_MS) / `TICK_PERIOD_US,
    parameter PWM_W          = 14,
    parameter PWM_CYCLES     = `PWM_PERIOD_NS / `CLK_PERIOD_NS
)
(
    // Clock and reset.
    input  wire clock,
    input  wire rst,
    // User contacts, all active low.
    input  wire uncorkBtnN,
    input  wire removeBtnN,
    input  wire endSwitchN,
    // Bridge fault flags, high on fault.
    input  wire faultA,
    input  wire faultB,
    // Analog comparators.
    input  wire overcurrentCmp,
    input  wire regBelow,
    input  wire regAbove,
    input  wire regEqual,
    input  wire batteryOk,
    input  wire chargerPresent,
    // Bridge control.
    output reg  bridgeEnable_q,
    output reg  bridgePhase_q,
    output reg  decaySelect0_q,
    output reg  decaySelect1_q,
    output wire bridgePwm,
    // Power management and status.
    output reg  comparatorPower_q,
    output reg  powerDown_q,
    output reg  motorRun_q,
    output reg  redLed_q,
    output reg  blueLed_q
);

    localparam [2:0] ST_IDLE   = 3'h1;
    localparam [2:0] ST_UNCORK = 3'h2;
    localparam [2:0] ST_REMOVE = 3'h4;

    // Asynchronous level inputs pass two flops before any use.
    wire [`SY_COUNT-1:0] asyncIn;
    reg  [`SY_COUNT-1:0] syncMeta_q;
    reg  [`SY_COUNT-1:0] sync_q;

    reg [TICK_W-1:0] tickCnt_q;
    reg              tick_q;
    reg [RUN_W-1:0]  runCnt_q;

    wire uncorkLevel;
    wire removeLevel;
    wire switchLevel;
    reg  uncorkPrev_q;
    reg  removePrev_q;

    reg [2:0] state_q;
    reg [2:0] state_d;

    wire uncorkFall;
    wire removeFall;
    wire uncorkRise;
    wire removeRise;
    wire buttonChange;
    wire gateOk;
    wire timeout;
    wire endActive;
    wire uncorkTrigger;
    wire running;
    wire runningNext;

    assign asyncIn = {chargerPresent, batteryOk, regEqual, regAbove,
                      regBelow, overcurrentCmp, faultB, faultA};

    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            syncMeta_q <= {`SY_COUNT{1'b0}};
            sync_q     <= {`SY_COUNT{1'b0}};
        end
        else
        begin
            syncMeta_q <= asyncIn;
            sync_q     <= syncMeta_q;
        end
    end

    // One free-running tick paces every long duration in the block.
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            tickCnt_q <= {TICK_W{1'b0}};
            tick_q    <= 1'b0;
        end
        else if (tickCnt_q == TICK_CYCLES[TICK_W-1:0] - 1'b1)
        begin
            tickCnt_q <= {TICK_W{1'b0}};
            tick_q    <= 1'b1;
        end
        else
        begin
            tickCnt_q <= tickCnt_q + 1'b1;
            tick_q    <= 1'b0;
        end
    end

    // Contact filters.
    debounce_filter #(
        .CNT_W        (DEB_W),
        .STABLE_TICKS (DEBOUNCE_TICKS)
    ) uncorkFilter (
        .clock   (clock),
        .rst     (rst),
        .tick    (tick_q),
        .rawIn   (uncorkBtnN),
        .level_q (uncorkLevel)
    );

    debounce_filter #(
        .CNT_W        (DEB_W),
        .STABLE_TICKS (DEBOUNCE_TICKS)
    ) removeFilter (
        .clock   (clock),
        .rst     (rst),
        .tick    (tick_q),
        .rawIn   (removeBtnN),
        .level_q (removeLevel)
    );

    debounce_filter #(
        .CNT_W        (DEB_W),
        .STABLE_TICKS (DEBOUNCE_TICKS)
    ) switchFilter (
        .clock   (clock),
        .rst     (rst),
        .tick    (tick_q),
        .rawIn   (endSwitchN),
        .level_q (switchLevel)
    );

    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            uncorkPrev_q <= 1'b1;
            removePrev_q <= 1'b1;
        end
        else
        begin
            uncorkPrev_q <= uncorkLevel;
            removePrev_q <= removeLevel;
        end
    end

    assign uncorkFall   = uncorkPrev_q && !uncorkLevel;
    assign removeFall   = removePrev_q && !removeLevel;
    assign uncorkRise   = !uncorkPrev_q && uncorkLevel;
    assign removeRise   = !removePrev_q && removeLevel;
    assign buttonChange = (uncorkPrev_q ^ uncorkLevel) | (removePrev_q ^ removeLevel);

    // Comparators are powered from the press edge, so their answer has the
    // whole press to settle before the release edge samples it.
    assign gateOk    = sync_q[`SY_BATTOK] && !sync_q[`SY_CHARGER];
    assign timeout   = tick_q && (runCnt_q == RUN_TICKS[RUN_W-1:0] - 1'b1);
    assign endActive = !switchLevel;
    assign running   = (state_q != ST_IDLE);

    assign uncorkTrigger = (uncorkRise && (running || gateOk))
                           || (state_q == ST_UNCORK && timeout);

    // Stopping never waits for the battery gate; only starting does.
    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (uncorkTrigger)
                    state_d = ST_UNCORK;
                else if (removeRise && gateOk)
                    state_d = ST_REMOVE;
            end
            ST_UNCORK:
            begin
                if (uncorkTrigger || endActive)
                    state_d = ST_IDLE;
            end
            ST_REMOVE:
            begin
                if (removeRise || timeout)
                    state_d = ST_IDLE;
            end
            default:
                state_d = ST_IDLE;
        endcase
    end

    assign runningNext = (state_d != ST_IDLE);

    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_q  <= ST_IDLE;
            runCnt_q <= {RUN_W{1'b0}};
        end
        else
        begin
            state_q <= state_d;
            if (!running)
                runCnt_q <= {RUN_W{1'b0}};
            else if (tick_q)
                runCnt_q <= runCnt_q + 1'b1;
        end
    end

    // Power for the comparators: a press edge sets it and wins over any clear.
    always @(posedge clock or posedge rst)
    begin
        if (rst)
            comparatorPower_q <= 1'b0;
        else if (buttonChange && (uncorkFall || removeFall))
            comparatorPower_q <= 1'b1;
        else if (!runningNext && (running || buttonChange))
            comparatorPower_q <= 1'b0;
    end

    // Bridge and status outputs, all registered.
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            bridgeEnable_q <= 1'b0;
            bridgePhase_q  <= 1'b0;
            decaySelect0_q <= `DECAY_SLOW;
            decaySelect1_q <= `DECAY_SLOW;
            powerDown_q    <= 1'b1;
            motorRun_q     <= 1'b0;
            redLed_q       <= 1'b0;
            blueLed_q      <= 1'b0;
        end
        else
        begin
            bridgeEnable_q <= runningNext && !sync_q[`SY_FAULTA]
                              && !sync_q[`SY_FAULTB];
            bridgePhase_q  <= (state_d == ST_REMOVE);
            decaySelect0_q <= `DECAY_SLOW;
            decaySelect1_q <= `DECAY_SLOW;
            powerDown_q    <= !runningNext;
            motorRun_q     <= runningNext;
            redLed_q       <= (state_d == ST_UNCORK);
            blueLed_q      <= (state_d == ST_REMOVE);
        end
    end

    pwm_chopper #(
        .PWM_W         (PWM_W),
        .PERIOD_CYCLES (PWM_CYCLES),
        .BLANK_W       (BLANK_W),
        .BLANK_TICKS   (BLANK_TICKS)
    ) chopper (
        .clock       (clock),
        .rst         (rst),
        .tick        (tick_q),
        .run         (motorRun_q),
        .overcurrent (sync_q[`SY_OVERCUR]),
        .regBelow    (sync_q[`SY_BELOW]),
        .regAbove    (sync_q[`SY_ABOVE]),
        .regEqual    (sync_q[`SY_EQUAL]),
        .pwmOut_q    (bridgePwm)
    );

endmodule

/* tb/corkscrew_far_side.sv */
`timescale 1ns/1ps
module corkscrew_far_side
(
    // Clock and bench commands.
    input  wire       clock,
    input  wire [2:0] press,
    input  wire [1:0] faultInj,
    input  wire       ocInj,
    // Bridge drive.
    input  wire       bridgeEnable_q,
    // Contacts and flags.
    output reg  [2:0] contactN_q,
    output wire       faultA,
    output wire       faultB,
    output wire       overcurrentCmp
);
    reg [2:0] last_q = 3'h0;
    reg [2:0] mask_q = 3'h0;
    reg [1:0] bnc_q  = 2'h0;

    initial contactN_q = 3'h7;

    // Springs chatter for a few cycles after each change, so one press is several edges.
    always @(negedge clock)
    begin
        last_q <= press;
        if (press != last_q)
        begin
            mask_q <= press ^ last_q;
            bnc_q <= 2'h3;
        end
        else if (bnc_q != 2'h0)
            bnc_q <= bnc_q - 2'h1;
        contactN_q <= ~press ^ (mask_q & {3{bnc_q[0]}});
    end

    assign faultA = faultInj[0];
    assign faultB = faultInj[1];
    // Winding current only flows while the bridge is driven.
    assign overcurrentCmp = ocInj & bridgeEnable_q;
endmodule

/* tb/corkscrew_motor_control_sva.sv */
`timescale 1ns/1ps
module corkscrew_motor_control_sva
#(
    parameter TICK_CYCLES    = 200000,
    parameter RUN_TICKS      = 30000,
    parameter DEBOUNCE_TICKS = 10,
    parameter BLANK_TICKS    = 5
)
(
    input wire clock,
    input wire rst,
    input wire endSwitchN,
    input wire faultA,
    input wire faultB,
    input wire overcurrentCmp,
    input wire batteryOk,
    input wire chargerPresent,
    input wire bridgeEnable_q,
    input wire bridgePhase_q,
    input wire decaySelect0_q,
    input wire decaySelect1_q,
    input wire bridgePwm,
    input wire powerDown_q,
    input wire motorRun_q,
    input wire redLed_q,
    input wire blueLed_q
);
    localparam longint RUN_MAX = longint'(RUN_TICKS) * TICK_CYCLES + 4;
    localparam int END_MAX   = (DEBOUNCE_TICKS + 1) * TICK_CYCLES + 12;
    localparam int BLANK_END = (BLANK_TICKS + 1) * TICK_CYCLES + 4;
    reg [39:0] runCnt_q;
    reg [31:0] endCnt_q;

    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            runCnt_q <= 40'h0;
            endCnt_q <= 32'h0;
        end
        else
        begin
            runCnt_q <= motorRun_q ? runCnt_q + 40'h1 : 40'h0;
            endCnt_q <= (!endSwitchN && motorRun_q && !bridgePhase_q) ? endCnt_q + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence faultHeld;
        (faultA || faultB) [*4];
    endsequence
    sequence cleanRun;
        (motorRun_q && !faultA && !faultB) [*5];
    endsequence
    sequence ocHeld;
        (overcurrentCmp && runCnt_q > BLANK_END) [*4];
    endsequence

    decay_hold_a: assert property (decaySelect0_q && decaySelect1_q)
        else $error("decay select low");
    fault_off_a: assert property (faultHeld |-> !bridgeEnable_q)
        else $error("bridge enabled during fault");
    clean_on_a: assert property (cleanRun |-> bridgeEnable_q)
        else $error("bridge not enabled");
    run_only_a: assert property (bridgeEnable_q |-> motorRun_q)
        else $error("bridge enabled while idle");
    oc_chop_a: assert property (ocHeld ##0 bridgePwm |=> !bridgePwm)
        else $error("overcurrent did not chop");
    led_excl_a: assert property (!(redLed_q && blueLed_q))
        else $error("both lamps lit");
    red_dir_a: assert property (redLed_q |-> motorRun_q && !bridgePhase_q)
        else $error("uncork lamp or phase wrong");
    blue_dir_a: assert property (blueLed_q |-> motorRun_q && bridgePhase_q)
        else $error("remove lamp or phase wrong");
    lamp_run_a: assert property (motorRun_q == (redLed_q || blueLed_q))
        else $error("run without lamp");
    pdown_run_a: assert property (powerDown_q == !motorRun_q)
        else $error("power down level wrong");
    start_gate_a: assert property ($rose(motorRun_q) |-> batteryOk && !chargerPresent)
        else $error("start while supply not fit");
    run_limit_a: assert property (runCnt_q <= RUN_MAX)
        else $error("run timer overran");
    end_stop_a: assert property (endCnt_q <= END_MAX)
        else $error("end switch did not stop");
endmodule

bind corkscrew_motor_control corkscrew_motor_control_sva #(
    .TICK_CYCLES(TICK_CYCLES), .RUN_TICKS(RUN_TICKS),
    .DEBOUNCE_TICKS(DEBOUNCE_TICKS), .BLANK_TICKS(BLANK_TICKS)
) i_sva (
    .clock(clock), .rst(rst), .endSwitchN(endSwitchN), .faultA(faultA), .faultB(faultB),
    .overcurrentCmp(overcurrentCmp), .batteryOk(batteryOk), .chargerPresent(chargerPresent),
    .bridgeEnable_q(bridgeEnable_q), .bridgePhase_q(bridgePhase_q),
    .decaySelect0_q(decaySelect0_q), .decaySelect1_q(decaySelect1_q), .bridgePwm(bridgePwm),
    .powerDown_q(powerDown_q), .motorRun_q(motorRun_q), .redLed_q(redLed_q),
    .blueLed_q(blueLed_q));

/* tb/corkscrew_motor_control_tb_top.sv */
`timescale 1ns/1ps
module corkscrew_motor_control_tb_top;
    localparam TC = 10;
    localparam RT = 200;
    localparam PC = 40;
    localparam [4:0] IDLE = 5'h01;
    localparam [4:0] UNC  = 5'h18;
    localparam [4:0] REM  = 5'h16;
    reg        clock = 1'b0;
    reg        rst = 1'b1;
    reg  [2:0] press = 3'h0;
    reg  [1:0] faultInj = 2'h0;
    reg        ocInj = 1'b0;
    reg        batteryOk = 1'b1;
    reg        chargerPresent = 1'b0;
    reg  [2:0] regCmp = 3'h4;
    reg        regHold = 1'b0;
    reg  [2:0] regForce = 3'h4;
    reg  [4:0] h1;
    reg  [4:0] h2;
    reg  [7:0] seed = 8'h04;
    reg  [4:0] prev_q = 5'h01;
    reg  [4:0] expQ [$];
    integer    fails = 0;
    integer    check_count = 0;
    wire [2:0] contactN;
    wire       faultA, faultB, overcurrentCmp;
    wire       bridgeEnable_q, bridgePhase_q, decaySelect0_q, decaySelect1_q, bridgePwm;
    wire       comparatorPower_q, powerDown_q, motorRun_q, redLed_q, blueLed_q;
    wire [4:0] status = {motorRun_q, redLed_q, blueLed_q, bridgePhase_q, powerDown_q};
    wire [1:0] watch = {bridgePwm, motorRun_q};

    always #2.5 clock = ~clock;

    corkscrew_motor_control #(.TICK_CYCLES(TC), .RUN_TICKS(RT), .DEBOUNCE_TICKS(2),
        .BLANK_TICKS(2), .PWM_CYCLES(PC)) i_dut (
        .clock(clock), .rst(rst), .uncorkBtnN(contactN[0]), .removeBtnN(contactN[1]),
        .endSwitchN(contactN[2]), .faultA(faultA), .faultB(faultB),
        .overcurrentCmp(overcurrentCmp), .regBelow(regCmp[0]), .regAbove(regCmp[1]),
        .regEqual(regCmp[2]), .batteryOk(batteryOk), .chargerPresent(chargerPresent),
        .bridgeEnable_q(bridgeEnable_q), .bridgePhase_q(bridgePhase_q),
        .decaySelect0_q(decaySelect0_q), .decaySelect1_q(decaySelect1_q),
        .bridgePwm(bridgePwm), .comparatorPower_q(comparatorPower_q),
        .powerDown_q(powerDown_q), .motorRun_q(motorRun_q), .redLed_q(redLed_q),
        .blueLed_q(blueLed_q));

    corkscrew_far_side i_far (.clock(clock), .press(press), .faultInj(faultInj),
        .ocInj(ocInj), .bridgeEnable_q(bridgeEnable_q), .contactN_q(contactN),
        .faultA(faultA), .faultB(faultB), .overcurrentCmp(overcurrentCmp));

    function [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Below is favoured so the duty never drifts low enough to hide the chopping.
    always @(negedge clock)
    begin
        seed <= lfsr(seed);
        regCmp <= regHold ? regForce : (seed[0] ? 3'h1 : (seed[1] ? 3'h2 : 3'h4));
    end

    task stop_test;
        begin
            if (fails == 0 && check_count > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    task chk(input [4:0] got, input [4:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp)
            begin
                fails = fails + 1;
                $display("Error at %0t: got %0h expected %0h", $time, got, exp);
            end
        end
    endtask

    task cyc(input integer n);
        repeat (n) @(negedge clock);
    endtask

    // Five bits suffice: only differences are compared, and they wrap alike.
    task dutyCount(output [4:0] h);
        integer i;
        begin
            h = 5'h00;
            for (i = 0; i < PC; i = i + 1)
            begin
                cyc(1);
                h = h + {4'h0, bridgePwm};
            end
        end
    endtask

    task waitBit(input integer k, input v, input integer n);
        integer i;
        begin
            for (i = 0; i < n && watch[k] !== v; i = i + 1)
                cyc(1);
            if (watch[k] !== v)
            begin
                chk({4'h0, watch[k]}, {4'h0, v});
                stop_test;
            end
        end
    endtask

    task push_btn(input integer b, input [4:0] exp, input integer note);
        begin
            if (note)
                expQ.push_back(exp);
            press[b] = 1'b1;
            cyc(45);
            if (b < 2)
                chk({4'h0, comparatorPower_q}, 5'h01);
            press[b] = 1'b0;
            cyc(55);
        end
    endtask

    always @(negedge clock)
    begin
        if (!rst && status !== prev_q)
        begin
            if (expQ.size() == 0)
                chk(status, prev_q);
            else
                chk(status, expQ.pop_front());
        end
        prev_q <= status;
    end

    initial
    begin
        cyc(4);
        rst = 1'b0;
        cyc(2);
        chk(status, IDLE);
        chk({comparatorPower_q, decaySelect0_q, decaySelect1_q, bridgePwm, bridgeEnable_q},
            5'h0C);
        batteryOk = 1'b0;
        push_btn(0, IDLE, 0);
        chk({4'h0, comparatorPower_q}, 5'h00);
        batteryOk = 1'b1;
        chargerPresent = 1'b1;
        push_btn(1, IDLE, 0);
        chargerPresent = 1'b0;
        push_btn(0, UNC, 1);
        chk({4'h0, bridgeEnable_q}, 5'h01);
        push_btn(1, UNC, 0);
        faultInj = 2'h1;
        cyc(6);
        chk({4'h0, bridgeEnable_q}, 5'h00);
        faultInj = 2'h2;
        cyc(6);
        chk({4'h0, bridgeEnable_q}, 5'h00);
        faultInj = 2'h0;
        cyc(6);
        chk({4'h0, bridgeEnable_q}, 5'h01);
        push_btn(0, IDLE, 1);
        push_btn(1, REM, 1);
        push_btn(2, REM, 0);
        push_btn(1, IDLE, 1);
        push_btn(0, UNC, 1);
        push_btn(2, IDLE, 1);
        push_btn(1, REM, 1);
        expQ.push_back(IDLE);
        cyc(RT * TC - 60);
        chk({4'h0, motorRun_q}, 5'h01);
        waitBit(0, 1'b0, 120);
        ocInj = 1'b1;
        expQ.push_back(UNC);
        press[0] = 1'b1;
        cyc(45);
        press[0] = 1'b0;
        waitBit(0, 1'b1, 60);
        cyc(3);
        waitBit(1, 1'b1, 6);
        chk({4'h0, bridgePwm}, 5'h01);
        cyc(40);
        chk({4'h0, bridgePwm}, 5'h00);
        ocInj = 1'b0;
        waitBit(1, 1'b1, 100);
        ocInj = 1'b1;
        cyc(3);
        chk({4'h0, bridgePwm}, 5'h00);
        cyc(3);
        ocInj = 1'b0;
        // Each held window spans a whole number of periods, so the step count is exact.
        regForce <= 3'h2;
        regHold <= 1'b1;
        cyc(PC * 10);
        regForce <= 3'h4;
        cyc(5);
        dutyCount(h1);
        regForce <= 3'h2;
        cyc(PC * 5);
        regForce <= 3'h4;
        cyc(5);
        dutyCount(h2);
        chk(h1 - h2, 5'h05);
        regForce <= 3'h1;
        cyc(PC * 5);
        regForce <= 3'h4;
        cyc(5);
        dutyCount(h2);
        chk(h2, h1);
        regHold <= 1'b0;
        push_btn(0, IDLE, 1);
        push_btn(0, UNC, 1);
        expQ.push_back(IDLE);
        waitBit(0, 1'b0, RT * TC + 100);
        cyc(10);
        chk(expQ.size() == 0 ? 5'h00 : 5'h1F, 5'h00);
        stop_test;
    end
endmodule
